// ===== core/flash_irq_and_lock_status_regs.sv
/*
  interrupt status, lock start block and write-protect status registers
  of the flash controller, plus an event status / clear / enable group.
  assumes a single-cycle strobe register port on mclk_i, and that
  completion events, resets, polarity and block select come from
  logic on the same clock.
*/
// Decided for this implementation: the plain strobed port.
// Operation
// [R1] interrupt status reads 8080h after cold reset and 8010h after warm or hot reset.
// [R2] the master interrupt bit at bit 15 drives the interrupt pin directly.
// [R3] clearing the master bit drives the pin low for high polarity, high for low polarity.
// [R4] the master bit sets when any done flag sets or a listed misc command completes.
// [R5] master, load, program and erase flags clear on a host zero write; load, program and erase also clear on warm or hot reset.
// [R6] the load flag at bit 7 sets on load, buffer load or boot completion.
// [R7] the program flag at bit 6 sets on program command completion.
// [R8] the erase flag at bit 5 sets on erase command completion.
// [R9] the reset flag at bit 4 sets on reset command completion or warm reset release.
// [R10] the host loads the target block into the lock start field before lock commands.
// [R11] the end block address offset is reserved and has no function.
// [R12] the host selects the block of interest before reading write-protect status.
// [R13] write-protect status shows unlocked on bit 2, locked on bit 1, tight on bit 0.
// [R14] write-protect status resets to 0002h, the locked state.
// [R15] host writes of one never set a flag; only device events set them.
`timescale 1ns/1ns
`default_nettype none
`include "flash_irq_regs.svh"

module flash_irq_and_lock_status_regs #(
  parameter int BLOCKS = 1024,
  parameter int AW     = 10
) (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  input  wire logic                     warm_rst_i,
  input  wire logic                     hot_rst_i,
  input  wire logic [15:0]              addr_i,
  input  wire logic [15:0]              wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [15:0]              rdata_o,
  input  wire flash_irq_pkg::op_evt_t   op_evt_i,
  input  wire flash_irq_pkg::lock_req_t lock_req_i,
  input  wire logic                     irq_pin_polarity_i,
  input  wire logic [AW-1:0]            flash_block_select_i,
  output logic      [AW-1:0]            lock_start_block_o,
  output logic                          int_pin_o,
  output logic                          irq_o
);

  //////////////////////////////////////////////////////////////////////
  // completion decode

  // returns {misc, reset, erase, program, load} completion hits
  function automatic logic [4:0] decode_evt(flash_irq_pkg::op_evt_t e);
    logic [4:0] h;
    h = 5'h00;
    if (e.done) begin
      case (e.cmd)
        `CMD_LOAD_A, `CMD_LOAD_B:               h[0] = 1'b1;
        `CMD_PROG_A, `CMD_PROG_B, `CMD_PROG_C:  h[1] = 1'b1;
        `CMD_ERASE_A, `CMD_ERASE_B,
        `CMD_ERASE_C:                           h[2] = 1'b1;
        `CMD_RST_A, `CMD_RST_B, `CMD_RST_C:     h[3] = 1'b1;
        `CMD_MISC_A, `CMD_MISC_B, `CMD_MISC_C,
        `CMD_MISC_D, `CMD_MISC_E:               h[4] = 1'b1;
        default:                                h = 5'h00;
      endcase
    end
    if (e.buf_load || e.boot) begin
      h[0] = 1'b1;
    end
    return h;
  endfunction

  function automatic logic [2:0] wp_bits(flash_irq_pkg::wp_state_t s);
    case (s)
      flash_irq_pkg::WP_UNLOCKED: return 3'b100;
      flash_irq_pkg::WP_TIGHT:    return 3'b001;
      default:                    return 3'b010;
    endcase
  endfunction

  logic [4:0]          hit;
  logic                warm_q_r;
  logic                warm_rel;
  logic                any_rst;
  logic                set_load;
  logic                set_prog;
  logic                set_erase;
  logic                set_rstd;
  logic                set_master;
  logic                wr_istat;

  assign hit        = decode_evt(op_evt_i);
  assign warm_rel   = warm_q_r & ~warm_rst_i;
  assign any_rst    = warm_rst_i | hot_rst_i;
  assign set_load   = hit[0];                                          // [R6]
  assign set_prog   = hit[1];                                          // [R7]
  assign set_erase  = hit[2];                                          // [R8]
  assign set_rstd   = hit[3] | warm_rel;                               // [R9]
  assign set_master = set_load | set_prog | set_erase | set_rstd | hit[4]; // [R4]
  assign wr_istat   = wr_i && addr_i == `ADDR_INT_STATUS;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      warm_q_r <= 1'b0;
    end else begin
      warm_q_r <= warm_rst_i;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt status flags

  logic master_r;
  logic load_r;
  logic prog_r;
  logic erase_r;
  logic rstd_r;
  logic [15:0] istat;

  // a bit-select needs a named constant, a bare literal cannot be indexed
  localparam logic [15:0] ISTAT_COLD_V = `ISTAT_COLD;
  localparam logic [15:0] ISTAT_WARM_V = `ISTAT_WARM;

  // a set in the same cycle as a zero write wins, so no completion is lost
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      master_r <= ISTAT_COLD_V[`BIT_MASTER];                           // [R1] [R5]
      load_r   <= ISTAT_COLD_V[`BIT_LOAD];
      prog_r   <= ISTAT_COLD_V[`BIT_PROG];
      erase_r  <= ISTAT_COLD_V[`BIT_ERASE];
      rstd_r   <= ISTAT_COLD_V[`BIT_RSTD];
    end else if (any_rst) begin
      master_r <= ISTAT_WARM_V[`BIT_MASTER];                           // [R1] [R5]
      load_r   <= ISTAT_WARM_V[`BIT_LOAD];
      prog_r   <= ISTAT_WARM_V[`BIT_PROG];
      erase_r  <= ISTAT_WARM_V[`BIT_ERASE];
      rstd_r   <= ISTAT_WARM_V[`BIT_RSTD];
    end else begin
      // writing one only keeps the flag      [R15]
      master_r <= set_master | (master_r & ~(wr_istat & ~wdata_i[`BIT_MASTER])); // [R5]
      load_r   <= set_load | (load_r & ~(wr_istat & ~wdata_i[`BIT_LOAD]));       // [R5]
      prog_r   <= set_prog | (prog_r & ~(wr_istat & ~wdata_i[`BIT_PROG]));       // [R5]
      erase_r  <= set_erase | (erase_r & ~(wr_istat & ~wdata_i[`BIT_ERASE]));    // [R5]
      rstd_r   <= set_rstd | (rstd_r & ~(wr_istat & ~wdata_i[`BIT_RSTD]));       // [R9]
    end
  end

  always_comb begin
    istat              = 16'h0000;
    istat[`BIT_MASTER] = master_r;
    istat[`BIT_LOAD]   = load_r;
    istat[`BIT_PROG]   = prog_r;
    istat[`BIT_ERASE]  = erase_r;
    istat[`BIT_RSTD]   = rstd_r;
  end

  // pin is the master bit seen through the polarity setting
  assign int_pin_o = irq_pin_polarity_i ? master_r : ~master_r;       // [R2] [R3]

  //////////////////////////////////////////////////////////////////////
  // lock start block and write-protect state

  logic [AW-1:0]             lock_start_r;
  flash_irq_pkg::wp_state_t  sel_state;
  logic [15:0]               wp_status;

  always_ff @(posedge mclk_i) begin
    if (rst_i || any_rst) begin
      lock_start_r <= AW'(`LOCK_START_RESET);
    end else if (wr_i && addr_i == `ADDR_LOCK_START) begin
      lock_start_r <= wdata_i[AW-1:0];                                // [R10]
    end
  end

  assign lock_start_block_o = lock_start_r;

  // lock commands act on the block already held in the start field
  wp_block_table #(
    .BLOCKS (BLOCKS),
    .AW     (AW)
  ) u_table (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .upd_i     (lock_req_i.valid),
    .op_i      (lock_req_i.op),
    .upd_blk_i (lock_start_r),                                        // [R10]
    .sel_blk_i (flash_block_select_i),                                // [R12]
    .state_o   (sel_state)
  );

  // status lags a select change by one cycle
  assign wp_status = {13'h0000, wp_bits(sel_state)};                  // [R13] [R14]

  //////////////////////////////////////////////////////////////////////
  // event interrupt group

  logic [`EVT_W-1:0] evt_set;
  logic [`EVT_W-1:0] evt_stat_r;
  logic [`EVT_W-1:0] evt_en_r;
  logic [`EVT_W-1:0] evt_clr;

  always_comb begin
    evt_set              = '0;
    evt_set[`EVT_LOAD]   = set_load;
    evt_set[`EVT_PROG]   = set_prog;
    evt_set[`EVT_ERASE]  = set_erase;
    evt_set[`EVT_RSTD]   = set_rstd;
    evt_set[`EVT_MISC]   = hit[4];
    evt_set[`EVT_LOCK]   = lock_req_i.valid;
  end

  assign evt_clr = (wr_i && addr_i == `ADDR_EVT_CLEAR) ? wdata_i[`EVT_W-1:0] : '0;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      evt_stat_r <= '0;
    end else begin
      evt_stat_r <= evt_set | (evt_stat_r & ~evt_clr);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      evt_en_r <= '0;
    end else if (wr_i && addr_i == `ADDR_EVT_ENABLE) begin
      evt_en_r <= wdata_i[`EVT_W-1:0];
    end
  end

  assign irq_o = |(evt_stat_r & evt_en_r);

  //////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge mclk_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= 16'h0000;
    end else begin
      case (addr_i)
        `ADDR_INT_STATUS: rdata_o <= istat;
        `ADDR_LOCK_START: rdata_o <= {{(16-AW){1'b0}}, lock_start_r};
        `ADDR_LOCK_END:   rdata_o <= 16'h0000;                        // [R11]
        `ADDR_WP_STATUS:  rdata_o <= wp_status;                       // [R13]
        `ADDR_EVT_STATUS: rdata_o <= {{(16-`EVT_W){1'b0}}, evt_stat_r};
        `ADDR_EVT_ENABLE: rdata_o <= {{(16-`EVT_W){1'b0}}, evt_en_r};
        default:          rdata_o <= 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks

  chk_cold_default: assert property ( // [R1]
    @(posedge mclk_i) $fell(rst_i) && !any_rst |-> istat == `ISTAT_COLD)
    else $error("interrupt status not 8080h after cold reset");

  chk_warm_default: assert property ( // [R1]
    @(posedge mclk_i) disable iff (rst_i)
    $fell(hot_rst_i) && !warm_rst_i |-> istat == `ISTAT_WARM)
    else $error("interrupt status not 8010h after hot reset");

  chk_pin_drop: assert property ( // [R3]
    @(posedge mclk_i) disable iff (rst_i)
    wr_istat && !wdata_i[`BIT_MASTER] && !set_master && !any_rst
      && irq_pin_polarity_i ##1 irq_pin_polarity_i |-> !int_pin_o)
    else $error("interrupt pin not inactive after master clear");

  chk_pin_level: assert property ( // [R2]
    @(posedge mclk_i) disable iff (rst_i)
    set_master && !any_rst ##1 !irq_pin_polarity_i |-> !int_pin_o)
    else $error("interrupt pin not low while pending at low polarity");

  chk_master_set: assert property ( // [R4]
    @(posedge mclk_i) disable iff (rst_i)
    (hit[4] || set_rstd) && !any_rst |=> master_r)
    else $error("master bit not set by completion");

  chk_flag_clear: assert property ( // [R5]
    @(posedge mclk_i) disable iff (rst_i)
    wr_istat && !wdata_i[`BIT_PROG] && !set_prog && !any_rst |=> !prog_r)
    else $error("program flag not cleared by zero write");

  chk_load_set: assert property ( // [R6]
    @(posedge mclk_i) disable iff (rst_i)
    (op_evt_i.boot || op_evt_i.buf_load) && !any_rst |=> load_r && master_r)
    else $error("load flag not set by load completion");

  chk_erase_set: assert property ( // [R8]
    @(posedge mclk_i) disable iff (rst_i)
    op_evt_i.done && op_evt_i.cmd == `CMD_ERASE_C && !any_rst |=> erase_r)
    else $error("erase flag not set by erase completion");

  chk_warm_release: assert property ( // [R9]
    @(posedge mclk_i) disable iff (rst_i)
    $fell(warm_rst_i) |-> rstd_r ##1 rstd_r)
    else $error("reset flag lost after warm reset release");

  chk_no_host_set: assert property ( // [R15]
    @(posedge mclk_i) disable iff (rst_i)
    wr_istat && !set_master && !any_rst |=> (istat & ~$past(istat)) == 16'h0000)
    else $error("host write set an interrupt flag");

  chk_rsvd_read: assert property ( // [R11]
    @(posedge mclk_i) disable iff (rst_i)
    rd_i && addr_i == `ADDR_LOCK_END |=> rdata_o == 16'h0000)
    else $error("reserved end block offset read nonzero");

  chk_wp_onehot: assert property ( // [R13]
    @(posedge mclk_i) disable iff (rst_i)
    rd_i && addr_i == `ADDR_WP_STATUS |=> $onehot(rdata_o[2:0]) && rdata_o[15:3] == 13'h0000)
    else $error("write-protect status not a single state bit");

  chk_wp_default: assert property ( // [R14]
    @(posedge mclk_i) $fell(rst_i) |-> wp_status == `WP_RESET)
    else $error("write-protect status not 0002h after reset");

  chk_prog_set: assert property ( // [R7]
    @(posedge mclk_i) disable iff (rst_i)
    op_evt_i.done && op_evt_i.cmd == `CMD_PROG_A && !any_rst |=> prog_r && master_r)
    else $error("program flag not set by program completion");

  chk_load_cmd: assert property ( // [R6]
    @(posedge mclk_i) disable iff (rst_i)
    op_evt_i.done && op_evt_i.cmd == `CMD_LOAD_B && !any_rst |=> load_r && master_r)
    else $error("load flag not set by load command completion");

  chk_rst_cmd: assert property ( // [R9]
    @(posedge mclk_i) disable iff (rst_i)
    op_evt_i.done && op_evt_i.cmd == `CMD_RST_B && !any_rst |=> rstd_r && master_r)
    else $error("reset flag not set by reset command completion");

  chk_rstd_sticky: assert property ( // [R9]
    @(posedge mclk_i) disable iff (rst_i)
    rstd_r && !(wr_istat && !wdata_i[`BIT_RSTD]) |=> rstd_r)
    else $error("reset flag cleared without a zero write");

  chk_reset_hold: assert property ( // [R1] [R5]
    @(posedge mclk_i) disable iff (rst_i)
    any_rst |=> istat == `ISTAT_WARM)
    else $error("interrupt status not 8010h during warm or hot reset");

  chk_load_clear: assert property ( // [R5]
    @(posedge mclk_i) disable iff (rst_i)
    wr_istat && !wdata_i[`BIT_LOAD] && !set_load && !any_rst |=> !load_r)
    else $error("load flag not cleared by zero write");

endmodule

`default_nettype wire

// ===== core/flash_irq_regs.svh
/*
  register offsets, field positions, reset values and command codes
  of the flash interrupt and write-protect register group.
  assumes 16-bit word addressing on the register port.
*/
`ifndef FLASH_IRQ_REGS_SVH
`define FLASH_IRQ_REGS_SVH

`define ADDR_INT_STATUS  16'hf241
`define ADDR_LOCK_START  16'hf24c
`define ADDR_LOCK_END    16'hf24d
`define ADDR_WP_STATUS   16'hf24e
`define ADDR_EVT_STATUS  16'hf250
`define ADDR_EVT_CLEAR   16'hf251
`define ADDR_EVT_ENABLE  16'hf252

`define BIT_MASTER       15
`define BIT_LOAD         7
`define BIT_PROG         6
`define BIT_ERASE        5
`define BIT_RSTD         4

`define ISTAT_COLD       16'h8080
`define ISTAT_WARM       16'h8010
`define WP_RESET         16'h0002
`define LOCK_START_RESET 10'h000

`define EVT_W            6
`define EVT_LOAD         0
`define EVT_PROG         1
`define EVT_ERASE        2
`define EVT_RSTD         3
`define EVT_MISC         4
`define EVT_LOCK         5

`define CMD_LOAD_A       16'h0000
`define CMD_LOAD_B       16'h0013
`define CMD_PROG_A       16'h0080
`define CMD_PROG_B       16'h001a
`define CMD_PROG_C       16'h001b
`define CMD_ERASE_A      16'h0094
`define CMD_ERASE_B      16'h0095
`define CMD_ERASE_C      16'h0030
`define CMD_RST_A        16'h00b0
`define CMD_RST_B        16'h00f0
`define CMD_RST_C        16'h00f3
`define CMD_MISC_A       16'h0065
`define CMD_MISC_B       16'h0023
`define CMD_MISC_C       16'h0071
`define CMD_MISC_D       16'h002a
`define CMD_MISC_E       16'h002c

`endif

// ===== core/flash_irq_pkg.sv
/*
  types shared by the interrupt / write-protect register group.
  assumes nothing beyond a sv compiler.
*/
package flash_irq_pkg;

  // gray along unlocked -> locked -> locked-tight
  typedef enum logic [1:0] {
    WP_UNLOCKED = 2'b00,
    WP_LOCKED   = 2'b01,
    WP_TIGHT    = 2'b11
  } wp_state_t;

  typedef enum logic [1:0] {
    LK_UNLOCK = 2'b00,
    LK_LOCK   = 2'b01,
    LK_TIGHT  = 2'b10
  } lock_op_t;

  typedef struct packed {
    logic        done;
    logic [15:0] cmd;
    logic        buf_load;
    logic        boot;
  } op_evt_t;

  typedef struct packed {
    logic     valid;
    lock_op_t op;
  } lock_req_t;

endpackage

// ===== core/wp_block_table.sv
/*
  per-block write-protect state memory with a registered lookup.
  assumes update and select come from logic on mclk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module wp_block_table #(
  parameter int BLOCKS = 1024,
  parameter int AW     = 10
) (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  input  wire logic                     upd_i,
  input  wire flash_irq_pkg::lock_op_t  op_i,
  input  wire logic [AW-1:0]            upd_blk_i,
  input  wire logic [AW-1:0]            sel_blk_i,
  output flash_irq_pkg::wp_state_t      state_o
);

  flash_irq_pkg::wp_state_t mem_r [BLOCKS];

  // a tight block only leaves that state through cold reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < BLOCKS; i++) begin
        mem_r[i] <= flash_irq_pkg::WP_LOCKED;
      end
    end else if (upd_i && mem_r[upd_blk_i] != flash_irq_pkg::WP_TIGHT) begin
      case (op_i)
        flash_irq_pkg::LK_UNLOCK: mem_r[upd_blk_i] <= flash_irq_pkg::WP_UNLOCKED;
        flash_irq_pkg::LK_LOCK:   mem_r[upd_blk_i] <= flash_irq_pkg::WP_LOCKED;
        flash_irq_pkg::LK_TIGHT: begin
          if (mem_r[upd_blk_i] == flash_irq_pkg::WP_LOCKED) begin
            mem_r[upd_blk_i] <= flash_irq_pkg::WP_TIGHT;
          end
        end
        default: mem_r[upd_blk_i] <= mem_r[upd_blk_i];
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_o <= flash_irq_pkg::WP_LOCKED;
    end else begin
      state_o <= mem_r[sel_blk_i];
    end
  end

endmodule

`default_nettype wire

// ===== tb/host_bus_model.sv
/*
  host processor model: register port cycles, lock commands and block
  selection for the interrupt / write-protect register group.
  assumes a one-cycle strobe port on mclk_i with read data the cycle after.
*/
`timescale 1ns/1ns
`default_nettype none
`include "flash_irq_regs.svh"

module host_bus_model #(
  parameter int AW = 10
) (
  input  wire logic                 mclk_i,
  input  wire logic [15:0]          rdata_i,
  output logic      [15:0]          addr_o,
  output logic      [15:0]          wdata_o,
  output logic                      wr_o,
  output logic                      rd_o,
  output flash_irq_pkg::lock_req_t  lock_req_o,
  output logic      [AW-1:0]        blk_sel_o
);
  initial begin
    addr_o     = 16'h0000;
    wdata_o    = 16'h0000;
    wr_o       = 1'b0;
    rd_o       = 1'b0;
    lock_req_o = '0;
    blk_sel_o  = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask

  // data is taken only in the single cycle that it stands
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    @(negedge mclk_i);
    d = rdata_i;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // start block first, then the command pulse
  task automatic lock_cmd(input logic [AW-1:0] blk, input flash_irq_pkg::lock_op_t op);
    wr_reg(`ADDR_LOCK_START, {{(16-AW){1'b0}}, blk});
    @(posedge mclk_i);
    lock_req_o <= '{valid: 1'b1, op: op};
    @(posedge mclk_i);
    lock_req_o <= '0;
  endtask

  // table lookup and read register give two cycles of latency
  task automatic wp_read(input logic [AW-1:0] blk, output logic [15:0] d);
    @(posedge mclk_i);
    blk_sel_o <= blk;
    repeat (3) @(posedge mclk_i);
    rd_reg(`ADDR_WP_STATUS, d);
  endtask
endmodule
`default_nettype wire

// ===== tb/flash_irq_and_lock_status_regs_tb.sv
/*
  self-checking bench for the interrupt and write-protect register group.
  assumes the package, header, design and host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "flash_irq_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module flash_irq_and_lock_status_regs_tb;
  logic                      mclk = 1'b0;
  logic                      rst = 1'b1;
  logic                      warm_rst = 1'b0;
  logic                      hot_rst = 1'b0;
  logic                      pol = 1'b1;
  logic [15:0]               addr, wdata, rdata;
  logic                      wr, rd, int_pin, irq;
  logic [9:0]                blk_sel, lock_start;
  flash_irq_pkg::op_evt_t    op_evt = '0;
  flash_irq_pkg::lock_req_t  lock_req;
  int                        fail_count = 0;
  int                        compares = 0;

  always #50 mclk = ~mclk;

  flash_irq_and_lock_status_regs i_dut (
    .mclk_i(mclk), .rst_i(rst), .warm_rst_i(warm_rst), .hot_rst_i(hot_rst),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .op_evt_i(op_evt), .lock_req_i(lock_req), .irq_pin_polarity_i(pol),
    .flash_block_select_i(blk_sel), .lock_start_block_o(lock_start),
    .int_pin_o(int_pin), .irq_o(irq)
  );

  host_bus_model i_host (
    .mclk_i(mclk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .lock_req_o(lock_req), .blk_sel_o(blk_sel)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_host.rd_reg(a, d);
    `CHK(d, e)
  endtask

  task automatic wp_chk(input logic [9:0] b, input logic [15:0] e);
    logic [15:0] d;
    i_host.wp_read(b, d);
    `CHK(d, e)
  endtask

  task automatic evt(input logic dn, input logic [15:0] c, input logic bl, input logic bt);
    @(posedge mclk);
    op_evt <= '{done: dn, cmd: c, buf_load: bl, boot: bt};
    @(posedge mclk);
    op_evt <= '0;
  endtask

  task automatic set_pol(input logic p);
    @(posedge mclk);
    pol <= p;
    @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(`ADDR_INT_STATUS, 16'h8080);
    rd_chk(`ADDR_WP_STATUS, 16'h0002);
    rd_chk(`ADDR_LOCK_START, 16'h0000);
    `CHK(int_pin, 1'b1)
    set_pol(1'b0);
    `CHK(int_pin, 1'b0)
    set_pol(1'b1);
  endtask

  task automatic t_clear;
    i_host.wr_reg(`ADDR_INT_STATUS, 16'h0080);
    rd_chk(`ADDR_INT_STATUS, 16'h0080);
    `CHK(int_pin, 1'b0)
    set_pol(1'b0);
    `CHK(int_pin, 1'b1)
    set_pol(1'b1);
    i_host.wr_reg(`ADDR_INT_STATUS, 16'hffff);
    rd_chk(`ADDR_INT_STATUS, 16'h0080);
    i_host.wr_reg(`ADDR_INT_STATUS, 16'h0000);
    rd_chk(`ADDR_INT_STATUS, 16'h0000);
  endtask

  // every completion code, then the buffer-load and boot strobes
  task automatic t_events;
    logic [15:0] cmds [16] = '{16'h0000, 16'h0013, 16'h0080, 16'h001a, 16'h001b,
      16'h0094, 16'h0095, 16'h0030, 16'h00b0, 16'h00f0, 16'h00f3, 16'h0065,
      16'h0023, 16'h0071, 16'h002a, 16'h002c};
    logic [15:0] exps [16] = '{16'h8080, 16'h8080, 16'h8040, 16'h8040, 16'h8040,
      16'h8020, 16'h8020, 16'h8020, 16'h8010, 16'h8010, 16'h8010, 16'h8000,
      16'h8000, 16'h8000, 16'h8000, 16'h8000};
    for (int i = 0; i < 16; i++) begin
      evt(1'b1, cmds[i], 1'b0, 1'b0);
      rd_chk(`ADDR_INT_STATUS, exps[i]);
      i_host.wr_reg(`ADDR_INT_STATUS, 16'h0000);
    end
    evt(1'b0, 16'h0000, 1'b1, 1'b0);
    rd_chk(`ADDR_INT_STATUS, 16'h8080);
    i_host.wr_reg(`ADDR_INT_STATUS, 16'h0000);
    evt(1'b0, 16'h0000, 1'b0, 1'b1);
    rd_chk(`ADDR_INT_STATUS, 16'h8080);
    i_host.wr_reg(`ADDR_INT_STATUS, 16'h0000);
  endtask

  task automatic t_resets;
    i_host.wr_reg(`ADDR_LOCK_START, 16'h0007);
    @(posedge mclk);
    warm_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    warm_rst <= 1'b0;
    rd_chk(`ADDR_INT_STATUS, 16'h8010);
    rd_chk(`ADDR_LOCK_START, 16'h0000);
    i_host.wr_reg(`ADDR_INT_STATUS, 16'h8000);
    rd_chk(`ADDR_INT_STATUS, 16'h8000);
    @(posedge mclk);
    hot_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    hot_rst <= 1'b0;
    rd_chk(`ADDR_INT_STATUS, 16'h8010);
    i_host.wr_reg(`ADDR_INT_STATUS, 16'h0000);
  endtask

  // tight is entered only from locked and then ignores unlock
  task automatic t_lock;
    wp_chk(10'd5, 16'h0002);
    i_host.lock_cmd(10'd5, flash_irq_pkg::LK_UNLOCK);
    `CHK(lock_start, 10'd5)
    rd_chk(`ADDR_LOCK_START, 16'h0005);
    wp_chk(10'd5, 16'h0004);
    wp_chk(10'd6, 16'h0002);
    i_host.lock_cmd(10'd5, flash_irq_pkg::LK_TIGHT);
    wp_chk(10'd5, 16'h0004);
    i_host.lock_cmd(10'd5, flash_irq_pkg::LK_LOCK);
    wp_chk(10'd5, 16'h0002);
    i_host.lock_cmd(10'd5, flash_irq_pkg::LK_TIGHT);
    wp_chk(10'd5, 16'h0001);
    i_host.lock_cmd(10'd5, flash_irq_pkg::LK_UNLOCK);
    wp_chk(10'd5, 16'h0001);
    i_host.wr_reg(`ADDR_LOCK_END, 16'hffff);
    rd_chk(`ADDR_LOCK_END, 16'h0000);
    i_host.wr_reg(`ADDR_WP_STATUS, 16'hffff);
    rd_chk(`ADDR_WP_STATUS, 16'h0001);
    rd_chk(16'hf2ff, 16'h0000);
  endtask

  // earlier scenarios left every event bit pending, lock included
  task automatic t_irq;
    rd_chk(`ADDR_EVT_STATUS, 16'h003f);
    i_host.wr_reg(`ADDR_EVT_CLEAR, 16'h003f);
    i_host.wr_reg(`ADDR_EVT_ENABLE, 16'h0002);
    rd_chk(`ADDR_EVT_ENABLE, 16'h0002);
    evt(1'b1, 16'h0080, 1'b0, 1'b0);
    @(negedge mclk);
    `CHK(irq, 1'b1)
    rd_chk(`ADDR_EVT_STATUS, 16'h0002);
    i_host.wr_reg(`ADDR_EVT_CLEAR, 16'h0002);
    @(negedge mclk);
    `CHK(irq, 1'b0)
    rd_chk(`ADDR_EVT_CLEAR, 16'h0000);
    i_host.wr_reg(`ADDR_EVT_ENABLE, 16'h0000);
    evt(1'b1, 16'h0094, 1'b0, 1'b0);
    @(negedge mclk);
    `CHK(irq, 1'b0)
    rd_chk(`ADDR_EVT_STATUS, 16'h0004);
    rd_chk(`ADDR_INT_STATUS, 16'h8060);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // whole sequence needs well under 20000 cycles
  initial begin
    #(100 * 20000);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_clear();
    t_events();
    t_resets();
    t_lock();
    t_irq();
    finish_test();
  end
endmodule
`default_nettype wire
